// >>> verilog/pitr_pkg.sv
`default_nettype none
package pitr_pkg;
    // Register offsets as byte addresses on the register port
    localparam logic [15:0] PRIMARY_OFS = 16'hF1C4;
    localparam logic [15:0] SECONDARY_OFS = 16'hEB26;
    localparam logic [15:0] P9_SEL_OFS = 16'hEB98;
    localparam logic [15:0] P9_SET_OFS = 16'hEB9A;
    localparam logic [15:0] P9_CLR_OFS = 16'hEB9C;
    localparam logic [15:0] P10_SEL_OFS = 16'hEBD8;
    // Implemented bit masks; other bits are reserved
    localparam logic [15:0] PRIMARY_MASK = 16'h00FF;
    localparam logic [15:0] SECONDARY_MASK = 16'h003F;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Primary bit positions
    localparam int P2_LOW_BIT = 0;
    localparam int P2_HIGH_BIT = 1;
    localparam int P3_LOW_BIT = 2;
    localparam int P3_HIGH_BIT = 3;
    localparam int P4_LOW_BIT = 4;
    localparam int P6_LOW_BIT = 5;
    localparam int P7_LOW_BIT = 6;
    localparam int P8_LOW_BIT = 7;
    // Secondary bit positions
    localparam int P0_LOW_BIT = 0;
    localparam int P0_HIGH_BIT = 1;
    localparam int P1_LOW_BIT = 2;
    localparam int P1_HIGH_BIT = 3;
    localparam int P5_LOW_BIT = 4;
    localparam int P5_HIGH_BIT = 5;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pitr_req_s;

    // One bit per byte: 1 = CMOS thresholds, 0 = TTL
    typedef struct packed {
        logic port8Low;
        logic port7Low;
        logic port6Low;
        logic port5High;
        logic port5Low;
        logic port4Low;
        logic port3High;
        logic port3Low;
        logic port2High;
        logic port2Low;
        logic port1High;
        logic port1Low;
        logic port0High;
        logic port0Low;
    } pitr_bytesel_s;
endpackage
`default_nettype wire

// >>> verilog/pitr_line_reg.sv
`timescale 1ns/10ps
`default_nettype none
// Sixteen-bit line select with plain write, set and clear strobes
module pitr_line_reg
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Update strobes
    input wire logic wrEn,
    input wire logic setEn,
    input wire logic clrEn,
    input wire logic [15:0] wdata,
    // Stored value
    output logic [15:0] value
);
    import pitr_pkg::*;

    typedef struct packed {
        logic [15:0] bits;
    } pitr_line_s;

    pitr_line_s st_reg;
    pitr_line_s st_next;

    always_comb
    begin
        st_next = st_reg;
        if (wrEn)
        begin
            st_next.bits = wdata;
        end
        else if (setEn)
        begin
            st_next.bits = st_reg.bits | wdata;
        end
        else if (clrEn)
        begin
            st_next.bits = st_reg.bits & ~wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= REG_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign value = st_reg.bits;
endmodule
`default_nettype wire

// >>> verilog/pitr_regs.sv
`timescale 1ns/10ps
`default_nettype none
module pitr_regs
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire pitr_pkg::pitr_req_s req,
    output logic [15:0] rdata,
    // Threshold selects
    output pitr_pkg::pitr_bytesel_s byteCmos,
    output logic [15:0] port9LineCmosSelect,
    output logic [15:0] port10LineCmosSelect
);
    import pitr_pkg::*;

    typedef struct packed {
        logic [7:0] primary;
        logic [5:0] secondary;
        logic [15:0] rdata;
    } pitr_state_s;

    pitr_state_s st_reg;
    pitr_state_s st_next;
    logic [15:0] p9Value;
    logic [15:0] p10Value;
    logic hitPri;
    logic hitSec;
    logic hitP9;
    logic hitP9Set;
    logic hitP9Clr;
    logic hitP10;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
        hit = (a == o);
    endfunction

    always_comb
    begin
        hitPri = hit(req.addr, PRIMARY_OFS);
        hitSec = hit(req.addr, SECONDARY_OFS);
        hitP9 = hit(req.addr, P9_SEL_OFS);
        hitP9Set = hit(req.addr, P9_SET_OFS);
        hitP9Clr = hit(req.addr, P9_CLR_OFS);
        hitP10 = hit(req.addr, P10_SEL_OFS);
    end

    // Whole-word writes at P9_SEL_OFS; the set/clear path avoids read-modify-write
    pitr_line_reg u_port9
    (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(req.wrEn && hitP9),
        .setEn(req.wrEn && hitP9Set),
        .clrEn(req.wrEn && hitP9Clr),
        .wdata(req.wdata),
        .value(p9Value)
    );

    // Port 10 set/clear companions are not provided here
    pitr_line_reg u_port10
    (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(req.wrEn && hitP10),
        .setEn(1'b0),
        .clrEn(1'b0),
        .wdata(req.wdata),
        .value(p10Value)
    );

    always_comb
    begin
        st_next = st_reg;
        if (req.wrEn && hitPri)
        begin
            st_next.primary = req.wdata[7:0];
        end
        if (req.wrEn && hitSec)
        begin
            st_next.secondary = req.wdata[5:0];
        end
        st_next.rdata = 16'h0000;
        if (req.rdEn)
        begin
            if (hitPri)
            begin
                st_next.rdata = {8'h00, st_reg.primary} & PRIMARY_MASK;
            end
            else if (hitSec)
            begin
                st_next.rdata = {10'h000, st_reg.secondary} & SECONDARY_MASK;
            end
            else if (hitP9)
            begin
                st_next.rdata = p9Value;
            end
            else if (hitP10)
            begin
                st_next.rdata = p10Value;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs: primary/secondary decoded from flops, lines from submodule flops
    assign rdata = st_reg.rdata;
    assign byteCmos.port2Low = st_reg.primary[P2_LOW_BIT];
    assign byteCmos.port3Low = st_reg.primary[P3_LOW_BIT];
    assign byteCmos.port4Low = st_reg.primary[P4_LOW_BIT];
    assign byteCmos.port6Low = st_reg.primary[P6_LOW_BIT];
    assign byteCmos.port7Low = st_reg.primary[P7_LOW_BIT];
    assign byteCmos.port8Low = st_reg.primary[P8_LOW_BIT];
    assign byteCmos.port2High = st_reg.primary[P2_HIGH_BIT];
    assign byteCmos.port3High = st_reg.primary[P3_HIGH_BIT];
    assign byteCmos.port0High = st_reg.secondary[P0_HIGH_BIT];
    assign byteCmos.port1High = st_reg.secondary[P1_HIGH_BIT];
    assign byteCmos.port5High = st_reg.secondary[P5_HIGH_BIT];
    assign byteCmos.port0Low = st_reg.secondary[P0_LOW_BIT];
    assign byteCmos.port1Low = st_reg.secondary[P1_LOW_BIT];
    assign byteCmos.port5Low = st_reg.secondary[P5_LOW_BIT];
    assign port9LineCmosSelect = p9Value;
    assign port10LineCmosSelect = p10Value;

    property p_p9_set;
        @(posedge clk) disable iff (!rst_n)
        (req.wrEn && hitP9Set) |=> ((port9LineCmosSelect & $past(req.wdata))
            == $past(req.wdata));
    endproperty
    a_p9_set: assert property (p_p9_set) else $error("set missed");

    property p_p9_clr;
        @(posedge clk) disable iff (!rst_n)
        (req.wrEn && hitP9Clr) |=> ((port9LineCmosSelect & $past(req.wdata))
            == 16'h0000);
    endproperty
    a_p9_clr: assert property (p_p9_clr) else $error("clear missed");

    property p_p9_keep;
        @(posedge clk) disable iff (!rst_n)
        (req.wrEn && hitP9Set) |=> ((port9LineCmosSelect & ~$past(req.wdata))
            == ($past(port9LineCmosSelect) & ~$past(req.wdata)));
    endproperty
    a_p9_keep: assert property (p_p9_keep) else $error("set disturbed");

    property p_p9_clr_keep;
        @(posedge clk) disable iff (!rst_n)
        (req.wrEn && hitP9Clr) |=> ((port9LineCmosSelect & ~$past(req.wdata))
            == ($past(port9LineCmosSelect) & ~$past(req.wdata)));
    endproperty
    a_p9_clr_keep: assert property (p_p9_clr_keep) else $error("clr disturbed");

    property p_p10_wr;
        @(posedge clk) disable iff (!rst_n)
        (req.wrEn && hitP10) |=> (port10LineCmosSelect == $past(req.wdata));
    endproperty
    a_p10_wr: assert property (p_p10_wr) else $error("p10 write");

    property p_p9_wr;
        @(posedge clk) disable iff (!rst_n)
        (req.wrEn && hitP9) |=> (port9LineCmosSelect == $past(req.wdata));
    endproperty
    a_p9_wr: assert property (p_p9_wr) else $error("p9 write");

    property p_pri;
        @(posedge clk) disable iff (!rst_n)
        (req.wrEn && hitPri) |=> (byteCmos.port8Low == $past(req.wdata[7])
            && byteCmos.port7Low == $past(req.wdata[6])
            && byteCmos.port6Low == $past(req.wdata[5])
            && byteCmos.port4Low == $past(req.wdata[4])
            && byteCmos.port3Low == $past(req.wdata[2])
            && byteCmos.port2Low == $past(req.wdata[0]));
    endproperty
    a_pri: assert property (p_pri) else $error("primary low");

    property p_pri_hi;
        @(posedge clk) disable iff (!rst_n)
        (req.wrEn && hitPri) |=> (byteCmos.port3High == $past(req.wdata[3])
            && byteCmos.port2High == $past(req.wdata[1]));
    endproperty
    a_pri_hi: assert property (p_pri_hi) else $error("primary high");

    property p_sec;
        @(posedge clk) disable iff (!rst_n)
        (req.wrEn && hitSec) |=> (byteCmos.port5High == $past(req.wdata[5])
            && byteCmos.port1High == $past(req.wdata[3])
            && byteCmos.port0High == $past(req.wdata[1]));
    endproperty
    a_sec: assert property (p_sec) else $error("secondary");

    property p_sec_lo;
        @(posedge clk) disable iff (!rst_n)
        (req.wrEn && hitSec) |=> (byteCmos.port5Low == $past(req.wdata[4])
            && byteCmos.port1Low == $past(req.wdata[2])
            && byteCmos.port0Low == $past(req.wdata[0]));
    endproperty
    a_sec_lo: assert property (p_sec_lo) else $error("secondary low");

    property p_rd_wo;
        @(posedge clk) disable iff (!rst_n)
        (req.rdEn && (hitP9Set || hitP9Clr)) |=> (rdata == 16'h0000);
    endproperty
    a_rd_wo: assert property (p_rd_wo) else $error("wo read");
endmodule
`default_nettype wire

// >>> tb/pitr_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module pitr_regs_test;
    import pitr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    pitr_req_s req = '0;
    logic [15:0] rdata;
    pitr_bytesel_s byteCmos;
    logic [15:0] port9LineCmosSelect;
    logic [15:0] port10LineCmosSelect;
    int failures = 0;
    int tests_run = 0;

    always #25 clk = ~clk;

    pitr_regs u_pitr_regs
    (
        .clk(clk),
        .rst_n(rst_n),
        .req(req),
        .rdata(rdata),
        .byteCmos(byteCmos),
        .port9LineCmosSelect(port9LineCmosSelect),
        .port10LineCmosSelect(port10LineCmosSelect)
    );

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Expected select vector from the two byte registers
    function automatic logic [15:0] sel(input logic [15:0] p,
                                        input logic [15:0] s);
        pitr_bytesel_s e;
        e.port8Low = p[7];
        e.port7Low = p[6];
        e.port6Low = p[5];
        e.port4Low = p[4];
        e.port3High = p[3];
        e.port3Low = p[2];
        e.port2High = p[1];
        e.port2Low = p[0];
        e.port5High = s[5];
        e.port5Low = s[4];
        e.port1High = s[3];
        e.port1Low = s[2];
        e.port0High = s[1];
        e.port0Low = s[0];
        return {2'b00, e};
    endfunction

    // Outputs are looked at 1 ns after the taking edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req.wrEn <= 1'b0;
        #1;
    endtask

    task automatic rdChk(input string what, input logic [15:0] a,
                         input logic [15:0] exp);
        @(posedge clk);
        req <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        req.rdEn <= 1'b0;
        #1;
        check(what, rdata, exp);
    endtask

    task automatic outChk(input logic [15:0] s, input logic [15:0] p9,
                          input logic [15:0] p10);
        check("byteCmos", {2'b00, byteCmos}, s);
        check("port9", port9LineCmosSelect, p9);
        check("port10", port10LineCmosSelect, p10);
    endtask

    task automatic testReset();
        outChk(16'h0000, 16'h0000, 16'h0000);
        rdChk("primary", PRIMARY_OFS, 16'h0000);
        rdChk("secondary", SECONDARY_OFS, 16'h0000);
        rdChk("p9", P9_SEL_OFS, 16'h0000);
        rdChk("p10", P10_SEL_OFS, 16'h0000);
    endtask

    // Odd and even bit patterns tell low-byte and high-byte bits apart in the secondary; primary bits 4 to 7 are all low-byte bits
    task automatic testBytes();
        wr(PRIMARY_OFS, 16'hFFFF);
        rdChk("primary", PRIMARY_OFS, 16'h00FF);
        wr(PRIMARY_OFS, 16'h0055);
        outChk(sel(16'h0055, 16'h0000), 16'h0000, 16'h0000);
        wr(PRIMARY_OFS, 16'h00AA);
        outChk(sel(16'h00AA, 16'h0000), 16'h0000, 16'h0000);
        wr(SECONDARY_OFS, 16'hFFFF);
        rdChk("secondary", SECONDARY_OFS, 16'h003F);
        wr(SECONDARY_OFS, 16'h0015);
        outChk(sel(16'h00AA, 16'h0015), 16'h0000, 16'h0000);
        wr(SECONDARY_OFS, 16'h002A);
        outChk(sel(16'h00AA, 16'h002A), 16'h0000, 16'h0000);
    endtask

    task automatic testLines();
        wr(P9_SEL_OFS, 16'h1234);
        outChk(sel(16'h00AA, 16'h002A), 16'h1234, 16'h0000);
        wr(P9_SET_OFS, 16'h8001);
        check("p9 set", port9LineCmosSelect, 16'h9235);
        wr(P9_CLR_OFS, 16'h1201);
        check("p9 clr", port9LineCmosSelect, 16'h8034);
        rdChk("setter", P9_SET_OFS, 16'h0000);
        rdChk("clearer", P9_CLR_OFS, 16'h0000);
        rdChk("p9", P9_SEL_OFS, 16'h8034);
        wr(P10_SEL_OFS, 16'hA5C3);
        wr(P9_SET_OFS, 16'h0000);
        outChk(sel(16'h00AA, 16'h002A), 16'h8034, 16'hA5C3);
        rdChk("p10", P10_SEL_OFS, 16'hA5C3);
    endtask

    // An unmapped write must disturb nothing; reset mid-run clears all
    task automatic testRefused();
        wr(16'hEB9E, 16'hFFFF);
        rdChk("unmapped", 16'hEB9E, 16'h0000);
        outChk(sel(16'h00AA, 16'h002A), 16'h8034, 16'hA5C3);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        testReset();
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        testReset();
        testBytes();
        // Extension ports are taken as already enabled by software
        testLines();
        testRefused();
        conclude();
    end

    // About 70 cycles are needed; the limit leaves ample margin
    initial
    begin
        #200000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
